// >>> core/mrz_mode_reg_zero.sv
// mode register zero: command decode, storage and field decode
`timescale 1ns/1ps

module mrz_mode_reg_zero #(
    parameter logic [15:0] WR_SUPPORTED = mrz_pkg::WR_SUPPORT_ALL,
    parameter logic [31:0] CL_SUPPORTED = mrz_pkg::CL_SUPPORT_ALL
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pin_cke,
    input wire logic pin_cs_n,
    input wire logic pin_act_n,
    input wire logic pin_ras_n,
    input wire logic pin_cas_n,
    input wire logic pin_we_n,
    input wire logic [1:0] pin_bg,
    input wire logic [1:0] pin_ba,
    input wire logic pin_a17,
    input wire logic [13:0] pin_a,
    output logic [21:0] mode_reg_zero,
    output logic other_reg_write,
    output logic [2:0] other_reg_index,
    output logic [4:0] write_gap_clocks,
    output logic [3:0] read_to_precharge_gap,
    output logic [5:0] read_delay_clocks,
    output logic burst_order_select,
    output logic [1:0] burst_size_select,
    output logic vendor_test_select,
    output logic dll_reset_pulse,
    output logic setting_reserved,
    output logic setting_unsupported
);

    logic [5:0] cmd_s;
    logic [18:0] addr_s;
    logic [21:0] raw_value;
    logic [2:0] sel_code;
    logic mrs_hit;
    logic mrs_zero;

    logic [21:0] mode_q, mode_d;
    logic other_q, other_d;
    logic [2:0] index_q, index_d;
    logic dll_q, dll_d;
    logic [4:0] wr_q, wr_d;
    logic [3:0] rtp_q, rtp_d;
    logic [5:0] cl_q, cl_d;
    logic rsv_q, rsv_d;
    logic unsup_q, unsup_d;
    logic [3:0] wr_code;
    logic [4:0] cl_code;

    // pins arrive from outside; command pins reset with cke low and the rest high so reset cannot fake a write
    mrz_pin_sync #(
        .WIDTH(mrz_pkg::CMD_WIDTH),
        .RESET_VALUE(mrz_pkg::CMD_IDLE)
    ) u_cmd_sync (
        .clock(clock),
        .rst_n(rst_n),
        .pin_in({pin_cke, pin_cs_n, pin_act_n, pin_ras_n, pin_cas_n, pin_we_n}),
        .pin_sync(cmd_s)
    );

    mrz_pin_sync #(
        .WIDTH(mrz_pkg::ADDR_WIDTH),
        .RESET_VALUE(mrz_pkg::ADDR_RESET)
    ) u_addr_sync (
        .clock(clock),
        .rst_n(rst_n),
        .pin_in({pin_bg, pin_ba, pin_a17, pin_a}),
        .pin_sync(addr_s)
    );

    // write gap code to clocks, zero for reserved codes
    function automatic logic [4:0] wr_decode(input logic [3:0] code);
        logic [4:0] res;
        res = 5'h00;
        case (code)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: res = 5'h0a + {code[3:0], 1'b0};
            4'h6: res = 5'h18;
            4'h7: res = 5'h16;
            4'h8: res = 5'h1a;
            4'h9: res = 5'h1c;
            default: res = 5'h00;
        endcase
        return res;
    endfunction

    // read delay code to clocks, zero for reserved codes
    function automatic logic [5:0] cl_decode(input logic [4:0] code);
        logic [5:0] res;
        res = 6'h00;
        case (code)
            5'h00, 5'h01, 5'h02, 5'h03,
            5'h04, 5'h05, 5'h06, 5'h07: res = 6'h09 + {3'h0, code[2:0]};
            5'h08, 5'h09, 5'h0a, 5'h0b: res = 6'h12 + {3'h0, code[1:0], 1'b0};
            5'h0c: res = 6'h17;
            5'h0d: res = 6'h11;
            5'h0e: res = 6'h13;
            5'h0f: res = 6'h15;
            5'h10: res = 6'h19;
            5'h11: res = 6'h1a;
            5'h13: res = 6'h1c;
            5'h14, 5'h15, 5'h16, 5'h17: res = 6'h1d + {4'h0, code[1:0]};
            default: res = 6'h00;
        endcase
        return res;
    endfunction

    // command decode: write is chip select low, act_n high, ras/cas/we low
    assign raw_value = {addr_s[18:14], 3'h0, addr_s[13:0]};
    assign sel_code = raw_value[mrz_pkg::SEL_MSB:mrz_pkg::SEL_LSB];
    assign mrs_hit = (cmd_s == mrz_pkg::CMD_MRS);
    assign mrs_zero = mrs_hit && (sel_code == mrz_pkg::SEL_ZERO);

    // next register value, pulses and decoded fields
    always_comb begin
        mode_d = mode_q;
        if (mode_q[mrz_pkg::DLL_BIT]) begin
            mode_d[mrz_pkg::DLL_BIT] = 1'b0;
        end
        other_d = 1'b0;
        index_d = index_q;
        dll_d = 1'b0;
        if (mrs_zero) begin
            mode_d = raw_value;
            dll_d = raw_value[mrz_pkg::DLL_BIT];
        end else if (mrs_hit && sel_code != mrz_pkg::SEL_FORBIDDEN) begin
            other_d = 1'b1;
            index_d = sel_code;
        end
        wr_code = {mode_d[mrz_pkg::WR_HI_BIT], mode_d[mrz_pkg::WR_LO_MSB:mrz_pkg::WR_LO_LSB]};
        cl_code = {mode_d[mrz_pkg::CL_HI_BIT], mode_d[mrz_pkg::CL_MID_MSB:mrz_pkg::CL_MID_LSB],
                   mode_d[mrz_pkg::CL_LO_BIT]};
        wr_d = wr_decode(wr_code);
        rtp_d = wr_d[4:1];
        cl_d = cl_decode(cl_code);
        // reserved values are flagged but still stored; behaviour is then undefined
        rsv_d = (wr_d == 5'h00) || (cl_d == 6'h00) || mode_d[mrz_pkg::RSV_HI_BIT]
                || mode_d[mrz_pkg::RSV_LO_BIT]
                || (mode_d[mrz_pkg::BSIZE_MSB:mrz_pkg::BSIZE_LSB]
                    == mrz_pkg::BSIZE_RESERVED);
        unsup_d = !WR_SUPPORTED[wr_code] || !CL_SUPPORTED[cl_code];
    end

    // all state registers; decoded fields move in step with the stored value
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mode_q <= mrz_pkg::MODE_RESET;
            other_q <= 1'b0;
            index_q <= mrz_pkg::SEL_ZERO;
            dll_q <= 1'b0;
            // decoded fields reset to what the reset codes decode to
            wr_q <= mrz_pkg::WR_RESET_CLOCKS;
            rtp_q <= mrz_pkg::RTP_RESET_CLOCKS;
            cl_q <= mrz_pkg::CL_RESET_CLOCKS;
            rsv_q <= 1'b0;
            unsup_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            other_q <= other_d;
            index_q <= index_d;
            dll_q <= dll_d;
            wr_q <= wr_d;
            rtp_q <= rtp_d;
            cl_q <= cl_d;
            rsv_q <= rsv_d;
            unsup_q <= unsup_d;
        end
    end

    // outputs straight from flip-flops
    assign mode_reg_zero = mode_q;
    assign other_reg_write = other_q;
    assign other_reg_index = index_q;
    assign write_gap_clocks = wr_q;
    assign read_to_precharge_gap = rtp_q;
    assign read_delay_clocks = cl_q;
    assign burst_order_select = mode_q[mrz_pkg::ORDER_BIT];
    assign burst_size_select = mode_q[mrz_pkg::BSIZE_MSB:mrz_pkg::BSIZE_LSB];
    assign vendor_test_select = mode_q[mrz_pkg::TEST_BIT];
    assign dll_reset_pulse = dll_q;
    assign setting_reserved = rsv_q;
    assign setting_unsupported = unsup_q;

    // a write to register zero lands on the next edge with pins mapped in place
    property p_write_lands;
        @(posedge clock) disable iff (!rst_n)
        mrs_zero |=> (mode_q[13:0] == $past(addr_s[13:0]))
            && (mode_q[21:17] == $past(addr_s[18:14]));
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("write not stored");

    // a write to another register leaves register zero alone
    property p_others_untouched;
        @(posedge clock) disable iff (!rst_n)
        (mrs_hit && sel_code != mrz_pkg::SEL_ZERO)
            |=> (mode_q[21:9] == $past(mode_q[21:9])) && (mode_q[7:0] == $past(mode_q[7:0]));
    endproperty
    a_others_untouched: assert property (p_others_untouched) else $error("wrong register");

    // the forbidden select code raises no write strobe anywhere
    property p_forbidden_ignored;
        @(posedge clock) disable iff (!rst_n)
        (mrs_hit && sel_code == mrz_pkg::SEL_FORBIDDEN) |=> !other_reg_write && $stable(mode_q);
    endproperty
    a_forbidden_ignored: assert property (p_forbidden_ignored) else $error("select 7 acted");

    // write gap pairs, checked at both ends of the table
    property p_wr_decode;
        @(posedge clock) disable iff (!rst_n)
        ({mode_q[13], mode_q[11:9]} == 4'h9 |-> write_gap_clocks == 5'h1c)
            and ({mode_q[13], mode_q[11:9]} == 4'h6 |-> write_gap_clocks == 5'h18)
            and ({mode_q[13], mode_q[11:9]} == 4'h0 |-> read_to_precharge_gap == 4'h5);
    endproperty
    a_wr_decode: assert property (p_wr_decode) else $error("write gap decode wrong");

    // low read delay codes count up from nine
    property p_cl_low;
        @(posedge clock) disable iff (!rst_n)
        ({mode_q[12], mode_q[6:4], mode_q[2]} < 5'h08)
            |-> read_delay_clocks == 6'h09 + {3'h0, mode_q[5:4], mode_q[2]};
    endproperty
    a_cl_low: assert property (p_cl_low) else $error("low read delay wrong");

    // irregular read delay codes
    property p_cl_high;
        @(posedge clock) disable iff (!rst_n)
        ({mode_q[12], mode_q[6:4], mode_q[2]} == 5'h0d |-> read_delay_clocks == 6'h11)
            and ({mode_q[12], mode_q[6:4], mode_q[2]} == 5'h13 |-> read_delay_clocks == 6'h1c)
            and ({mode_q[12], mode_q[6:4], mode_q[2]} == 5'h17 |-> read_delay_clocks == 6'h20);
    endproperty
    a_cl_high: assert property (p_cl_high) else $error("upper read delay wrong");

    // reserved burst size is always flagged
    property p_bsize_reserved;
        @(posedge clock) disable iff (!rst_n)
        $past(mrs_zero) && burst_size_select == mrz_pkg::BSIZE_RESERVED |-> setting_reserved;
    endproperty
    a_bsize_reserved: assert property (p_bsize_reserved) else $error("reserved size unflagged");

    // dll reset bit shows for one cycle with its pulse, then clears
    property p_dll_self_clear;
        @(posedge clock) disable iff (!rst_n)
        mode_q[8] && !mrs_zero |-> dll_reset_pulse ##1 !mode_q[8] && !dll_reset_pulse;
    endproperty
    a_dll_self_clear: assert property (p_dll_self_clear) else $error("dll bit stuck");

    // a read delay outside the support set is reported
    property p_unsupported;
        @(posedge clock) disable iff (!rst_n)
        $past(mrs_zero) && !CL_SUPPORTED[{mode_q[12], mode_q[6:4], mode_q[2]}]
            |-> setting_unsupported;
    endproperty
    a_unsupported: assert property (p_unsupported) else $error("unsupported unflagged");

endmodule // mrz_mode_reg_zero

// >>> core/mrz_pin_sync.sv
// two-stage synchroniser for a group of device pins
`timescale 1ns/1ps

module mrz_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage1_d;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage2_d;

    // first stage feeds only the second one
    always_comb begin
        stage1_d = pin_in;
        stage2_d = stage1_q;
    end

    // reset to the idle level so no false command is seen at release
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stage1_q <= RESET_VALUE;
            stage2_q <= RESET_VALUE;
        end else begin
            stage1_q <= stage1_d;
            stage2_q <= stage2_d;
        end
    end

    assign pin_sync = stage2_q;

endmodule // mrz_pin_sync

// >>> core/mrz_pkg.sv
// package: field layout, codes and reset values of mode register zero
package mrz_pkg;

    localparam int MR_WIDTH = 22;
    localparam logic [21:0] MODE_RESET = 22'h00_0000;
    // decoded fields of the reset value, so outputs agree with the stored codes
    localparam logic [4:0] WR_RESET_CLOCKS = 5'h0a;
    localparam logic [3:0] RTP_RESET_CLOCKS = 4'h5;
    localparam logic [5:0] CL_RESET_CLOCKS = 6'h09;

    // field positions within the register
    localparam int SEL_LSB = 18;
    localparam int SEL_MSB = 20;
    localparam int RSV_HI_BIT = 21;
    localparam int RSV_LO_BIT = 17;
    localparam int WR_HI_BIT = 13;
    localparam int CL_HI_BIT = 12;
    localparam int WR_LO_MSB = 11;
    localparam int WR_LO_LSB = 9;
    localparam int DLL_BIT = 8;
    localparam int TEST_BIT = 7;
    localparam int CL_MID_MSB = 6;
    localparam int CL_MID_LSB = 4;
    localparam int ORDER_BIT = 3;
    localparam int CL_LO_BIT = 2;
    localparam int BSIZE_MSB = 1;
    localparam int BSIZE_LSB = 0;

    // register index codes carried on the select field
    localparam logic [2:0] SEL_ZERO = 3'h0;
    localparam logic [2:0] SEL_FORBIDDEN = 3'h7;

    // command pins packed as {cke, cs_n, act_n, ras_n, cas_n, we_n}
    localparam int CMD_WIDTH = 6;
    localparam logic [5:0] CMD_IDLE = 6'h1f;
    localparam logic [5:0] CMD_MRS = 6'h28;

    // address pins packed as {bg1, bg0, ba1, ba0, a17, a13..a0}
    localparam int ADDR_WIDTH = 19;
    localparam logic [18:0] ADDR_RESET = 19'h0_0000;

    // default support sets: every defined code is present
    localparam logic [15:0] WR_SUPPORT_ALL = 16'h03ff;
    localparam logic [31:0] CL_SUPPORT_ALL = 32'h00fb_ffff;

    typedef enum logic [1:0] {
        BSIZE_FIXED_EIGHT = 2'h0,
        BSIZE_ON_THE_FLY = 2'h1,
        BSIZE_FIXED_FOUR = 2'h2,
        BSIZE_RESERVED = 2'h3
    } mrz_burst_size_type;

endpackage

// >>> testbench/mrz_ctrl_model.sv
// controller model: issues mode register set commands on the device pins
`timescale 1ns/1ps

module mrz_ctrl_model (
    input wire logic clock,
    output logic pin_cke,
    output logic pin_cs_n,
    output logic pin_act_n,
    output logic pin_ras_n,
    output logic pin_cas_n,
    output logic pin_we_n,
    output logic [1:0] pin_bg,
    output logic [1:0] pin_ba,
    output logic pin_a17,
    output logic [13:0] pin_a
);
    // deselect with cke high, so the device sits idle between commands
    initial begin
        {pin_cke, pin_cs_n, pin_act_n, pin_ras_n, pin_cas_n, pin_we_n} <= 6'h3f;
        {pin_bg, pin_ba, pin_a17, pin_a} <= 19'h0_0000;
    end

    // one command cycle; afterwards the address lines show the inverse, not stale data
    task automatic mrs(input logic [21:0] word);
        @(posedge clock);
        {pin_cke, pin_cs_n, pin_act_n, pin_ras_n, pin_cas_n, pin_we_n} <= mrz_pkg::CMD_MRS;
        {pin_bg, pin_ba, pin_a17} <= word[21:17];
        pin_a <= word[13:0];
        @(posedge clock);
        {pin_cke, pin_cs_n, pin_act_n, pin_ras_n, pin_cas_n, pin_we_n} <= 6'h3f;
        {pin_bg, pin_ba, pin_a17} <= ~word[21:17];
        pin_a <= ~word[13:0];
    endtask
endmodule // mrz_ctrl_model

// >>> testbench/test_sdram_mode_register_zero.sv
// testbench: mode register zero writes, field decode and select handling
`timescale 1ns/1ps

module test_sdram_mode_register_zero;
    logic clock, rst_n;
    logic pin_cke, pin_cs_n, pin_act_n, pin_ras_n, pin_cas_n, pin_we_n, pin_a17;
    logic [1:0] pin_bg, pin_ba;
    logic [13:0] pin_a;
    logic [21:0] mode_reg_zero;
    logic other_reg_write, burst_order_select, vendor_test_select;
    logic dll_reset_pulse, setting_reserved, setting_unsupported;
    logic [2:0] other_reg_index;
    logic [4:0] write_gap_clocks;
    logic [3:0] read_to_precharge_gap;
    logic [5:0] read_delay_clocks;
    logic [1:0] burst_size_select;
    logic [21:0] w, last;
    int error_cnt, checks_done;
    // expected clock counts by code, 0 marks a reserved code
    int gap_tab[16] = '{10, 12, 14, 16, 18, 20, 24, 22, 26, 28, 0, 0, 0, 0, 0, 0};
    int cl_tab[32] = '{9, 10, 11, 12, 13, 14, 15, 16, 18, 20, 22, 24, 23, 17, 19, 21,
        25, 26, 0, 28, 29, 30, 31, 32, 0, 0, 0, 0, 0, 0, 0, 0};
    logic [21:0] rsv_m[3] = '{22'h20_0000, 22'h02_0000, 22'h01_c000};

    // read delay code 15 left out of the support set to exercise that flag
    mrz_mode_reg_zero #(.CL_SUPPORTED(32'h00fb_7fff)) mrz_mode_reg_zero_i (.clock, .rst_n,
        .pin_cke, .pin_cs_n, .pin_act_n, .pin_ras_n, .pin_cas_n, .pin_we_n, .pin_bg,
        .pin_ba, .pin_a17, .pin_a, .mode_reg_zero, .other_reg_write, .other_reg_index,
        .write_gap_clocks, .read_to_precharge_gap, .read_delay_clocks, .burst_order_select,
        .burst_size_select, .vendor_test_select, .dll_reset_pulse, .setting_reserved,
        .setting_unsupported);
    mrz_ctrl_model mrz_ctrl_model_i (.clock, .pin_cke, .pin_cs_n, .pin_act_n, .pin_ras_n,
        .pin_cas_n, .pin_we_n, .pin_bg, .pin_ba, .pin_a17, .pin_a);

    // 250 MHz command clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // scatter code fields onto their register bit positions
    function automatic logic [21:0] mk(input logic [3:0] wr, input logic [4:0] cl,
        input logic ord, input logic [1:0] sz);
        logic [21:0] v;
        v = 22'h00_0000;
        {v[13], v[11:9]} = wr;
        {v[12], v[6:4], v[2]} = cl;
        v[3] = ord;
        v[1:0] = sz;
        return v;
    endfunction

    task automatic chk(input string what, input logic [21:0] exp, input logic [21:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // model returns on the first sync edge; second stage, then the update edge
    task automatic put(input logic [21:0] v);
        mrz_ctrl_model_i.mrs(v);
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // a hang ends the run as a failure
    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        error_cnt = 0;
        checks_done = 0;
        rst_n <= 1'b0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        #1;
        chk("reset value", 22'h00_0000, mode_reg_zero);
        for (int c = 0; c < 16; c++) begin
            put(mk(c[3:0], 5'h00, 1'b0, 2'h0));
            chk("write gap", 22'(gap_tab[c]), 22'(write_gap_clocks));
            chk("read to precharge", 22'(gap_tab[c] / 2), 22'(read_to_precharge_gap));
            chk("reserved flag", 22'(c > 9), 22'(setting_reserved));
            chk("unsupported flag", 22'(c > 9), 22'(setting_unsupported));
        end
        for (int c = 0; c < 32; c++) begin
            put(mk(4'h1, c[4:0], 1'b0, 2'h0));
            chk("stored value", mk(4'h1, c[4:0], 1'b0, 2'h0), mode_reg_zero);
            chk("read delay", 22'(cl_tab[c]), 22'(read_delay_clocks));
            chk("reserved flag", 22'(cl_tab[c] == 0), 22'(setting_reserved));
            chk("unsupported flag", 22'(cl_tab[c] == 0 || c == 15), 22'(setting_unsupported));
        end
        for (int b = 0; b < 8; b++) begin
            put(mk(4'h1, 5'h03, b[2], b[1:0]));
            chk("burst order", 22'(b[2]), 22'(burst_order_select));
            chk("burst size", 22'(b[1:0]), 22'(burst_size_select));
            chk("reserved flag", 22'(b[1:0] == 2'h3), 22'(setting_reserved));
        end
        // dll reset bit stands one cycle, then the register clears it
        w = mk(4'h2, 5'h04, 1'b0, 2'h0) | 22'h00_0180;
        put(w);
        chk("dll pulse", 22'h00_0001, 22'(dll_reset_pulse));
        chk("vendor test", 22'h00_0001, 22'(vendor_test_select));
        @(posedge clock);
        #1;
        chk("dll pulse end", 22'h00_0000, 22'(dll_reset_pulse));
        chk("dll bit cleared", w & 22'h3f_feff, mode_reg_zero);
        for (int i = 0; i < 3; i++) begin
            w = mk(4'h2, 5'h04, 1'b0, 2'h0) | rsv_m[i];
            put(w);
            chk("stored value", w & 22'h3e_3fff, mode_reg_zero);
            chk("reserved flag", 22'(i < 2), 22'(setting_reserved));
        end
        last = w & 22'h3e_3fff;
        // other selects leave this register alone; select 7 is ignored entirely
        for (int s = 1; s < 8; s++) begin
            put(mk(4'h5, 5'h06, 1'b1, 2'h2) | (22'(s) << 18));
            chk("other write", 22'(s != 7), 22'(other_reg_write));
            chk("other index", 22'(s == 7 ? 6 : s), 22'(other_reg_index));
            chk("unchanged", last, mode_reg_zero);
            @(posedge clock);
            #1;
            chk("other write end", 22'h00_0000, 22'(other_reg_write));
        end
        report_and_stop();
    end
endmodule // test_sdram_mode_register_zero
